/* inc/ebd_cfg.svh */
/*
 External bus area decoder: offsets, field codes and counts.
 Assumes inclusion by ebd_top and the testbench.
*/
`ifndef EBD_CFG_SVH
`define EBD_CFG_SVH
// -------------------------------------------------
// Address fields
// -------------------------------------------------
`define EBD_AREA_HI      28
`define EBD_AREA_LO      26
`define EBD_PIN_ADDR_W   26
`define EBD_TOP_REGION   3'h7
`define EBD_AREA_CODE0   3'h0
`define EBD_AREA_IO      3'h1
`define EBD_AREA_CODE5   3'h5
`define EBD_AREA_CODE6   3'h6
`define EBD_AREA_RSVD    3'h7
// -------------------------------------------------
// Chip select indices
// -------------------------------------------------
`define EBD_NUM_CS       8
`define EBD_CS_A0        3'h0
`define EBD_CS_A5A       3'h4
`define EBD_CS_A5B       3'h5
`define EBD_CS_A6A       3'h6
`define EBD_CS_A6B       3'h7
// -------------------------------------------------
// Bus widths and memory kinds
// -------------------------------------------------
`define EBD_W8           2'h0
`define EBD_W16          2'h1
`define EBD_W32          2'h2
`define EBD_MEM_NORMAL   2'h0
`define EBD_MEM_BYTESEL  2'h1
`define EBD_MEM_SDRAM    2'h2
`define EBD_MEM_MPX      2'h3
// -------------------------------------------------
// Buffering
// -------------------------------------------------
`define EBD_FIFO_DEPTH   16
`endif

/* inc/ebd_pkg.sv */
/*
 Types of the external bus area decoder.
 Assumes ebd_cfg.svh on the include path.
*/
package ebd_pkg;
   // -------------------------------------------------
   // Request word
   // -------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
      logic        write;
   } ebd_req_t;
   // -------------------------------------------------
   // Per-area setup, idle-cycle setup and controller states
   // -------------------------------------------------
   typedef struct packed {
      logic [1:0] width;
      logic [1:0] mem;
      logic [3:0] rd_wait;
      logic [3:0] wr_wait;
   } ebd_area_cfg_t;
   typedef struct packed {
      logic [1:0] rw_same;
      logic [1:0] rw_diff;
      logic [1:0] rr_same;
      logic [1:0] rr_diff;
      logic [1:0] wr_first;
   } ebd_idle_cfg_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_GAP, ST_ADDR, ST_ACCESS, ST_GRANT
   } ebd_state_t;
endpackage : ebd_pkg

/* src/ebd_fifo.sv */
/*
 Request FIFO, flip-flop storage, valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ebd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;
   // -------------------------------------------------
   // Pointers and count
   // -------------------------------------------------
   always_comb begin
      in_ready  = (cnt_r != (AW+1)'(DEPTH));
      out_valid = (cnt_r != '0);
      out_data  = mem_r[rp_r];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wp_nxt    = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt    = pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt   = cnt_r;
      if (push && !pop) begin
         cnt_nxt = (AW+1)'(cnt_r + 1'b1);
      end else if (pop && !push) begin
         cnt_nxt = (AW+1)'(cnt_r - 1'b1);
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule : ebd_fifo

/* src/ebd_top.sv */
/*
 External bus area decoder: buffers requests, decodes areas,
 drives chip selects, strobes, SDRAM pins and bus arbitration.
 Assumes one 50 MHz clock; pins other than config are asynchronous.
*/
`timescale 1ns/1ps
`include "ebd_cfg.svh"
// Notes on behaviour
// - Cache bits excluded; areas decoded on lower 29 address bits only.
// - One map-select input chooses map 1 or map 2 for decoding.
// - Area taken from A28..A26; codes 000 and 010..110 select usable areas, 001 goes on-chip.
// - Bits 31..29 affect decoding only as top region 111; other shadows hit same place.
// - Area 0 select active throughout each area 0 access.
// - Area 5 uses first select in map 1, second in map 2.
// - Area 6 uses first select in map 1, second in map 2.
// - Top region goes to on-chip registers, no external cycle.
// - Width strap chooses 16 or 32 bit bus for area 0.
// - Strap low after reset gives 16 bits, high gives 32.
// - Lane write strobes follow byte enables on writes, and on byte-select or SDRAM reads.
// - For byte-select SRAM or SDRAM strobes qualify reads and writes.
// - In multiplexed cycles lane 3 strobe marks address hold.
// - Direction output acts as write enable for SDRAM, byte SRAM.
// - Read strobe active only while read data is expected.
// - SDRAM commands use row strobes as RAS, column strobes as CAS.
// - Clock enable output steers SDRAM low-power and self-refresh.
// - Frame output brackets multiplexed transfers on the area 6 second select only.
// - Per-area wait states, read and write counts independent.
// - Idle cycles between accesses, five independently set cases.
// - Area width 8, 16 or 32; wide transfers split into cycles.
// - Grant only after bus request, and shared bus released.
module ebd_top (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // Request stream
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  ebd_pkg::ebd_req_t           req,
   output logic                        rd_valid,
   output logic [31:0]                 rd_data,
   output logic                        internal_register_region,
   // Configuration
   input  wire logic                   map_select,
   input  ebd_pkg::ebd_area_cfg_t      area_cfg [`EBD_NUM_CS],
   input  ebd_pkg::ebd_idle_cfg_t      idle_cfg,
   input  wire logic                   self_refresh_req,
   input  wire logic                   area0_width_strap,
   // Address and data pins
   output logic [`EBD_PIN_ADDR_W-1:0]  addr_out,
   input  wire logic [31:0]            data_in,
   output logic [31:0]                 data_out,
   output logic                        data_oe,
   output logic                        bus_oe,
   // Chip selects
   output logic                        area0_select_n,
   output logic                        area2_select_n,
   output logic                        area3_select_n,
   output logic                        area4_select_n,
   output logic                        area5_first_select_n,
   output logic                        area5_second_select_n,
   output logic                        area6_first_select_n,
   output logic                        area6_second_select_n,
   // Strobes
   output logic                        cycle_start_strobe_n,
   output logic                        rd_n,
   output logic                        rd_wr,
   output logic                        lane3_write_strobe_n,
   output logic                        lane2_write_strobe_n,
   output logic                        lane1_write_strobe_n,
   output logic                        lane0_write_strobe_n,
   output logic                        frame_n,
   // SDRAM
   output logic                        upper_row_strobe_n,
   output logic                        low_half_row_strobe_n,
   output logic                        upper_column_strobe_n,
   output logic                        low_half_column_strobe_n,
   output logic                        cke,
   // Wait and arbitration
   input  wire logic                   wait_n,
   input  wire logic                   bus_request_in_n,
   output logic                        bus_grant_n
);
   import ebd_pkg::*;

   // -------------------------------------------------
   // Functions
   // -------------------------------------------------
   function automatic logic [2:0] cs_idx(input logic [2:0] code,
                                         input logic       map2);
      unique case (code)
         3'h0:    cs_idx = `EBD_CS_A0;
         3'h2:    cs_idx = 3'h1;
         3'h3:    cs_idx = 3'h2;
         3'h4:    cs_idx = 3'h3;
         3'h5:    cs_idx = map2 ? `EBD_CS_A5B : `EBD_CS_A5A;
         default: cs_idx = map2 ? `EBD_CS_A6B : `EBD_CS_A6A;
      endcase
   endfunction : cs_idx

   function automatic logic [1:0] lane_off(input logic [1:0] w,
                                           input logic [1:0] sub);
      unique case (w)
         `EBD_W8:  lane_off = sub;
         `EBD_W16: lane_off = {sub[0], 1'b0};
         default:  lane_off = 2'h0;
      endcase
   endfunction : lane_off

   function automatic logic sub_last(input logic [1:0] w,
                                     input logic [1:0] sub);
      unique case (w)
         `EBD_W8:  sub_last = (sub == 2'h3);
         `EBD_W16: sub_last = (sub == 2'h1);
         default:  sub_last = 1'b1;
      endcase
   endfunction : sub_last

   // -------------------------------------------------
   // Synchronisers
   // -------------------------------------------------
   logic        bus_request_in_s1, bus_request_in_s2, wait_s1, wait_s2;
   logic        strap_s1, strap_s2;
   logic [31:0] din_s1, din_s2;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bus_request_in_s1  <= 1'b1;
         bus_request_in_s2  <= 1'b1;
         wait_s1  <= 1'b1;
         wait_s2  <= 1'b1;
         din_s1   <= 32'h0;
         din_s2   <= 32'h0;
      end else begin
         bus_request_in_s1  <= bus_request_in_n;
         bus_request_in_s2  <= bus_request_in_s1;
         wait_s1  <= wait_n;
         wait_s2  <= wait_s1;
         din_s1   <= data_in;
         din_s2   <= din_s1;
      end
   end
   // Strap runs through reset so its level is settled at release
   always_ff @(posedge clk) begin
      strap_s1 <= area0_width_strap;
      strap_s2 <= strap_s1;
   end

   // -------------------------------------------------
   // Request FIFO
   // -------------------------------------------------
   ebd_req_t q_data;
   logic     q_valid, q_pop;
   ebd_fifo #(
      .WIDTH ($bits(ebd_req_t)),
      .DEPTH (`EBD_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   (req),
      .out_valid (q_valid),
      .out_ready (q_pop),
      .out_data  (q_data)
   );

   // -------------------------------------------------
   // State
   // -------------------------------------------------
   ebd_state_t  state_r, state_nxt;
   ebd_req_t    cur_r, cur_nxt;
   logic [2:0]  csi_r, csi_nxt;
   logic [1:0]  sub_r, sub_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        rdv_r, rdv_nxt, irr_r, irr_nxt;
   logic        pv_r, pv_nxt, pw_r, pw_nxt;
   logic [2:0]  pcs_r, pcs_nxt;
   logic        a0w32_r, a0w32_nxt, strap_done_r, strap_done_nxt;
   logic        cke_r, cke_nxt;
   logic [2:0]  q_code, q_cs;
   logic [1:0]  gap, w, mem, off;
   logic        first_r, first_nxt;

   // Effective width and kind of the current area
   always_comb begin
      mem = area_cfg[csi_r].mem;
      w   = area_cfg[csi_r].width;
      if (csi_r == `EBD_CS_A0) begin
         w = a0w32_r ? `EBD_W32 : `EBD_W16;
      end
      off = lane_off(w, sub_r);
   end

   // Decode and idle gap of the head request
   always_comb begin
      q_code = q_data.addr[`EBD_AREA_HI:`EBD_AREA_LO];
      q_cs   = cs_idx(q_code, map_select);
      gap    = 2'h0;
      if (pv_r) begin
         if (pw_r) begin
            gap = idle_cfg.wr_first;
         end else if (q_data.write) begin
            gap = (pcs_r == q_cs) ? idle_cfg.rw_same : idle_cfg.rw_diff;
         end else begin
            gap = (pcs_r == q_cs) ? idle_cfg.rr_same : idle_cfg.rr_diff;
         end
      end
   end

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      state_nxt      = state_r;
      cur_nxt        = cur_r;
      csi_nxt        = csi_r;
      sub_nxt        = sub_r;
      cnt_nxt        = cnt_r;
      rdata_nxt      = rdata_r;
      rdv_nxt        = 1'b0;
      irr_nxt        = 1'b0;
      pv_nxt         = pv_r;
      pw_nxt         = pw_r;
      pcs_nxt        = pcs_r;
      first_nxt      = first_r;
      q_pop          = 1'b0;
      strap_done_nxt = 1'b1;
      a0w32_nxt      = strap_done_r ? a0w32_r : strap_s2;
      cke_nxt        = !(self_refresh_req && state_r == ST_IDLE);
      unique case (state_r)
         ST_IDLE: begin
            if (!bus_request_in_s2) begin
               state_nxt = ST_GRANT;
               pv_nxt    = 1'b0;
            end else if (q_valid && cke_r) begin
               q_pop = 1'b1;
               if (q_data.addr[31:29] == `EBD_TOP_REGION ||
                   q_code == `EBD_AREA_IO) begin
                  irr_nxt = 1'b1;
               end else if (q_code != `EBD_AREA_RSVD) begin
                  cur_nxt   = q_data;
                  csi_nxt   = q_cs;
                  sub_nxt   = 2'h0;
                  cnt_nxt   = {2'h0, gap};
                  first_nxt = 1'b1;
                  state_nxt = ST_GAP;
               end
            end
         end
         ST_GAP: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               cnt_nxt   = cur_r.write ? area_cfg[csi_r].wr_wait
                                       : area_cfg[csi_r].rd_wait;
               state_nxt = (mem == `EBD_MEM_MPX) ? ST_ADDR : ST_ACCESS;
            end
         end
         ST_ADDR: begin
            state_nxt = ST_ACCESS;
         end
         ST_ACCESS: begin
            first_nxt = 1'b0;
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (wait_s2) begin
               for (int i = 0; i < 4; i++) begin
                  if (!cur_r.write && i < 4 - int'(off)) begin
                     rdata_nxt[8*(i+int'(off)) +: 8] = din_s2[8*i +: 8];
                  end
               end
               cnt_nxt = cur_r.write ? area_cfg[csi_r].wr_wait
                                     : area_cfg[csi_r].rd_wait;
               if (sub_last(w, sub_r)) begin
                  rdv_nxt   = !cur_r.write;
                  pv_nxt    = 1'b1;
                  pw_nxt    = cur_r.write;
                  pcs_nxt   = csi_r;
                  state_nxt = ST_IDLE;
               end else begin
                  sub_nxt   = sub_r + 2'h1;
                  first_nxt = 1'b1;
               end
            end
         end
         ST_GRANT: begin
            if (bus_request_in_s2) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r      <= ST_IDLE;
         cur_r        <= '0;
         csi_r        <= 3'h0;
         sub_r        <= 2'h0;
         cnt_r        <= 4'h0;
         rdata_r      <= 32'h0;
         rdv_r        <= 1'b0;
         irr_r        <= 1'b0;
         pv_r         <= 1'b0;
         pw_r         <= 1'b0;
         pcs_r        <= 3'h0;
         first_r      <= 1'b0;
         a0w32_r      <= 1'b0;
         strap_done_r <= 1'b0;
         cke_r        <= 1'b1;
      end else begin
         state_r      <= state_nxt;
         cur_r        <= cur_nxt;
         csi_r        <= csi_nxt;
         sub_r        <= sub_nxt;
         cnt_r        <= cnt_nxt;
         rdata_r      <= rdata_nxt;
         rdv_r        <= rdv_nxt;
         irr_r        <= irr_nxt;
         pv_r         <= pv_nxt;
         pw_r         <= pw_nxt;
         pcs_r        <= pcs_nxt;
         first_r      <= first_nxt;
         a0w32_r      <= a0w32_nxt;
         strap_done_r <= strap_done_nxt;
         cke_r        <= cke_nxt;
      end
   end

   // -------------------------------------------------
   // Pin drive
   // -------------------------------------------------
   logic [7:0] cs_n;
   logic [3:0] lane_be, ws_n;
   logic       act, sd, bsel;
   always_comb begin
      act      = (state_r == ST_ACCESS) || (state_r == ST_ADDR);
      sd       = (mem == `EBD_MEM_SDRAM);
      bsel     = (mem == `EBD_MEM_BYTESEL) || sd;
      lane_be  = 4'(cur_r.be >> off);
      cs_n     = 8'hff;
      if (act) begin
         cs_n[csi_r] = 1'b0;
      end
      ws_n = 4'hf;
      if (state_r == ST_ACCESS && (cur_r.write || bsel)) begin
         ws_n = ~lane_be;
      end
      if (mem == `EBD_MEM_MPX) begin
         ws_n[3] = (state_r != ST_ADDR);
      end
      rd_n     = !(state_r == ST_ACCESS && !cur_r.write);
      rd_wr    = !(act && cur_r.write);
      cycle_start_strobe_n = !(state_r == ST_ACCESS && first_r);
      frame_n  = !(act && mem == `EBD_MEM_MPX &&
                   csi_r == `EBD_CS_A6B);
      upper_row_strobe_n       = !(sd && first_r && act && csi_r == 3'h2);
      low_half_row_strobe_n    = !(sd && first_r && act && csi_r == 3'h1);
      upper_column_strobe_n    = !(sd && !first_r && act && csi_r == 3'h2);
      low_half_column_strobe_n = !(sd && !first_r && act && csi_r == 3'h1);
      addr_out = {cur_r.addr[`EBD_PIN_ADDR_W-1:2],
                  (w == `EBD_W32) ? cur_r.addr[1:0] : off};
      data_out = (state_r == ST_ADDR) ? cur_r.addr
                                      : (cur_r.wdata >> {off, 3'h0});
      data_oe  = (state_r == ST_ADDR) || (act && cur_r.write);
      bus_oe   = (state_r != ST_GRANT);
      bus_grant_n = (state_r != ST_GRANT);
   end
   // Row strobe on the first cycle of each beat, column strobes on the rest of it

   assign {area6_second_select_n, area6_first_select_n,
           area5_second_select_n, area5_first_select_n,
           area4_select_n, area3_select_n,
           area2_select_n, area0_select_n} = cs_n;
   assign {lane3_write_strobe_n, lane2_write_strobe_n,
           lane1_write_strobe_n, lane0_write_strobe_n} = ws_n;
   assign rd_valid = rdv_r;
   assign rd_data  = rdata_r;
   assign internal_register_region = irr_r;
   assign cke = cke_r;

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_IDLE_QUIET: assert property (
      (state_r == ST_IDLE || state_r == ST_GRANT) |-> (cs_n == 8'hff)
      && rd_n && (ws_n == 4'hf)) else $error("select active while idle");
   AST_GRANT_AFTER_REQ: assert property (
      $fell(bus_grant_n) |-> $past(!bus_request_in_s2))
      else $error("grant without request");
   AST_GRANT_RELEASE: assert property (
      !bus_grant_n |-> !bus_oe && !data_oe) else $error("bus not released");
   AST_NO_TOP_CYCLE: assert property (
      act |-> cur_r.addr[31:29] != `EBD_TOP_REGION && cur_r.addr[28:26]
      != `EBD_AREA_IO) else $error("external cycle to on-chip region");
   AST_AREA0_SEL: assert property (
      (act && cur_r.addr[28:26] == `EBD_AREA_CODE0) |-> cs_n == 8'hfe)
      else $error("area 0 select missing");
   AST_AREA5_MAP: assert property (
      (act && cur_r.addr[28:26] == `EBD_AREA_CODE5 && map_select)
      |-> !area5_second_select_n && area5_first_select_n)
      else $error("area 5 select wrong for map");
   AST_AREA6_MAP: assert property (
      (act && cur_r.addr[28:26] == `EBD_AREA_CODE6 && !map_select)
      |-> !area6_first_select_n && area6_second_select_n)
      else $error("area 6 select wrong for map");
   AST_RD_ONLY_READ: assert property (
      !rd_n |-> !cur_r.write && $past(state_r) != ST_IDLE)
      else $error("read strobe outside read");
   AST_CKE_SR: assert property (
      (self_refresh_req && state_r == ST_IDLE) |=> !cke)
      else $error("clock enable not dropped");
   AST_STRAP: assert property (
      $rose(strap_done_r) |-> a0w32_r == $past(strap_s2))
      else $error("strap not captured");
endmodule : ebd_top

/* verification/ebd_mem_model.sv */
/*
 Far-side memory model for ebd_top: returns an address pattern on reads.
 Assumes one clock shared with the device; no wait states are inserted.
*/
`timescale 1ns/1ps
module ebd_mem_model (
   // Clock
   input  wire logic        clk,
   // Device pins
   input  wire logic        rd_n,
   input  wire logic [25:0] addr_out,
   output logic      [31:0] data_in = '0,
   output logic             wait_n
);
   // ---------------------------------------------
   // Read data, toggling while not driven
   // ---------------------------------------------
   always @(posedge clk) begin
      data_in <= !rd_n ? {6'h0, addr_out} : ~data_in;
   end
   assign wait_n = 1'b1;
endmodule : ebd_mem_model

/* verification/tb_top.sv */
/*
 Testbench for ebd_top: decode table, lane strobes, arbitration.
 Assumes ebd_mem_model as far side; strap high, then low after a second reset.
*/
`timescale 1ns/1ps
`include "ebd_cfg.svh"
module tb_top;
   import ebd_pkg::*;
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0]  flg;
      logic [3:0]  be;
      logic [7:0]  sel;
      logic [3:0]  lane;
      logic [3:0]  starts;
   } ebd_row_t;
   logic          clk = 0, reset_n = 0, req_valid = 0, map_select = 0, clr = 1;
   logic          bus_request_in_n = 1, done = 0, seen_int = 0;
   logic          seen_rd = 0, seen_wr = 0, srr = 0, strap = 1, rd_wr, cke;
   ebd_req_t      req = '0;
   ebd_area_cfg_t area_cfg [`EBD_NUM_CS];
   logic          req_ready, rd_valid, irr, bus_oe, bus_grant_n, start_n, rd_n, wait_n;
   logic [31:0]   data_in, rd_data;
   logic [25:0]   addr_out;
   logic [7:0]    sel_n, seen_sel = '0;
   logic [3:0]    lane_n, seen_lane = '0, starts = '0;
   int            n_errors = 0, comparisons = 0, i;
   // Flags: map, write, on-chip; area 7 and its shadows never used
   ebd_row_t rows [11] = '{
      '{32'h00000100, 3'h0, 4'hf, 8'h01, 4'h0, 4'h1},
      '{32'ha0000100, 3'h0, 4'hf, 8'h01, 4'h0, 4'h1},
      '{32'h08000000, 3'h0, 4'hf, 8'h02, 4'h0, 4'h2},
      '{32'h0c000000, 3'h0, 4'hf, 8'h04, 4'h0, 4'h1},
      '{32'h10000000, 3'h2, 4'h5, 8'h08, 4'h5, 4'h1},
      '{32'h14000000, 3'h0, 4'hf, 8'h10, 4'h0, 4'h1},
      '{32'h14000000, 3'h4, 4'hf, 8'h20, 4'h0, 4'h1},
      '{32'h18000000, 3'h0, 4'hf, 8'h40, 4'h0, 4'h1},
      '{32'h38000000, 3'h4, 4'hf, 8'h80, 4'h0, 4'h1},
      '{32'he0000000, 3'h1, 4'hf, 8'h00, 4'h0, 4'h0},
      '{32'h04000000, 3'h1, 4'hf, 8'h00, 4'h0, 4'h0}};
   always #10 clk = ~clk;
   ebd_top dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .internal_register_region(irr),
      .map_select(map_select), .area_cfg(area_cfg), .idle_cfg('0), .self_refresh_req(srr),
      .area0_width_strap(strap), .addr_out(addr_out), .data_in(data_in), .data_out(),
      .data_oe(), .bus_oe(bus_oe), .area0_select_n(sel_n[0]), .area2_select_n(sel_n[1]),
      .area3_select_n(sel_n[2]), .area4_select_n(sel_n[3]),
      .area5_first_select_n(sel_n[4]), .area5_second_select_n(sel_n[5]),
      .area6_first_select_n(sel_n[6]), .area6_second_select_n(sel_n[7]),
      .cycle_start_strobe_n(start_n), .rd_n(rd_n), .rd_wr(rd_wr),
      .lane3_write_strobe_n(lane_n[3]), .lane2_write_strobe_n(lane_n[2]),
      .lane1_write_strobe_n(lane_n[1]), .lane0_write_strobe_n(lane_n[0]),
      .frame_n(), .upper_row_strobe_n(), .cke(cke),
      .low_half_row_strobe_n(), .upper_column_strobe_n(), .low_half_column_strobe_n(),
      .wait_n(wait_n), .bus_request_in_n(bus_request_in_n), .bus_grant_n(bus_grant_n));
   ebd_mem_model mem (.clk(clk), .rd_n(rd_n), .addr_out(addr_out), .data_in(data_in),
      .wait_n(wait_n));
   // ---------------------------------------------
   // Pin monitor
   // ---------------------------------------------
   always @(posedge clk) begin
      if (clr) begin
         {seen_sel, seen_lane, starts, done, seen_int, seen_rd, seen_wr} <= '0;
      end else begin
         seen_rd   <= seen_rd | !rd_n;
         seen_wr   <= seen_wr | !rd_wr;
         seen_sel  <= seen_sel | ~sel_n;
         seen_lane <= seen_lane | ~lane_n;
         starts    <= starts + {3'h0, !start_n};
         done      <= done | rd_valid | irr;
         seen_int  <= seen_int | irr;
      end
   end
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check
   function automatic logic [31:0] exp_rd(input logic [31:0] a, input logic [3:0] n);
      exp_rd = (n == 4'h2) ? {a[15:2], 2'h2, a[15:2], 2'h0} : {6'h0, a[25:0]};
   endfunction : exp_rd
   task automatic access(input ebd_row_t r);
      @(posedge clk);
      req_valid  <= 1;
      req        <= '{r.addr, ~r.addr, r.be, r.flg[1]};
      map_select <= r.flg[2];
      clr        <= 1;
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req_valid <= 0;
      clr       <= 0;
      @(negedge clk);
      for (i = 0; i < 30 && done !== 1'b1; i++) @(negedge clk);
      repeat (3) @(negedge clk);
   endtask : access
   task automatic summarize;
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      foreach (area_cfg[j]) area_cfg[j] = '{(j == 1) ? 2'h1 : 2'h2, 2'h0, 4'h3, 4'h0};
      repeat (6) @(posedge clk);
      reset_n <= 1;
      @(negedge clk);
      check(sel_n === 8'hff && bus_grant_n === 1'b1, "reset pins");
      foreach (rows[k]) begin
         access(rows[k]);
         check(seen_sel === rows[k].sel, "chip select");
         check(seen_int === rows[k].flg[0], "on-chip region");
         check(seen_lane === rows[k].lane, "lane strobes");
         check(starts === rows[k].starts, "sub-cycle count");
         check(done === ~rows[k].flg[1], "completion");
         check(seen_rd === (rows[k].flg[1:0] == 2'h0), "read strobe");
         check(seen_wr === rows[k].flg[1], "direction");
         if (rows[k].flg[1:0] == 2'h0)
            check(rd_data === exp_rd(rows[k].addr, rows[k].starts), "read data");
      end
      @(posedge clk);
      bus_request_in_n <= 0;
      for (i = 0; i < 10 && bus_grant_n !== 1'b0; i++) @(posedge clk);
      @(negedge clk);
      check(bus_grant_n === 1'b0 && bus_oe === 1'b0, "grant");
      check(sel_n === 8'hff && lane_n === 4'hf, "pins idle while granted");
      @(posedge clk);
      bus_request_in_n <= 1;
      for (i = 0; i < 10 && bus_grant_n !== 1'b1; i++) @(posedge clk);
      @(negedge clk);
      check(bus_grant_n === 1'b1 && bus_oe === 1'b1, "release");
      @(posedge clk);
      srr <= 1;
      repeat (2) @(negedge clk);
      check(cke === 1'b0, "clock enable low");
      @(posedge clk);
      srr <= 0;
      repeat (2) @(negedge clk);
      check(cke === 1'b1, "clock enable back");
      @(posedge clk);
      strap   <= 0;
      reset_n <= 0;
      repeat (6) @(posedge clk);
      reset_n <= 1;
      @(negedge clk);
      check(sel_n === 8'hff && bus_grant_n === 1'b1, "reset pins again");
      access(rows[0]);
      check(starts === 4'h2 && seen_sel === 8'h01, "narrow area 0");
      check(rd_data === exp_rd(rows[0].addr, 4'h2), "narrow read data");
      summarize();
   end
endmodule : tb_top
